/* File: verilog/csc_pkg.sv */
// constants and types of the capacitive sense control block
package csc_pkg;
   // ************************************************************
   // bus and register map
   // ************************************************************
   localparam int unsigned  CSC_AW            = 12;
   localparam int unsigned  CSC_DW            = 32;
   localparam logic [11:0]  CSC_CTRL_A_ADDR   = 12'h000;
   localparam logic [11:0]  CSC_CHANNEL_ADDR  = 12'h004;
   localparam logic [7:0]   CSC_CTRL_A_RST    = 8'h00;
   localparam logic [7:0]   CSC_CHANNEL_RST   = 8'h00;
   localparam logic [31:0]  CSC_ZERO_WORD     = 32'h0000_0000;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int unsigned  CSC_ENABLE_BIT    = 7;
   localparam int unsigned  CSC_REFRNG_BIT    = 6;
   localparam int unsigned  CSC_CURRNG_HI     = 3;
   localparam int unsigned  CSC_CURRNG_LO     = 2;
   localparam int unsigned  CSC_DIR_BIT       = 1;
   localparam int unsigned  CSC_T0XS_BIT      = 0;
   localparam int unsigned  CSC_CHAN_HI       = 3;
   localparam int unsigned  CSC_CHAN_LO       = 0;
   localparam int unsigned  CSC_PINS          = 8;

   // ************************************************************
   // codes
   // ************************************************************
   localparam logic [1:0]   CSC_CUR_NONE      = 2'h0;
   localparam logic [1:0]   CSC_CUR_LOW       = 2'h1;
   localparam logic [1:0]   CSC_CUR_MED       = 2'h2;
   localparam logic [1:0]   CSC_CUR_HIGH      = 2'h3;
   localparam logic [1:0]   CSC_T1_SRC_SENSE  = 2'h3;
   localparam logic [3:0]   CSC_CH_LAST_BASE  = 4'h7;
   localparam logic [3:0]   CSC_CH_LAST_WIDE  = 4'hb;
   localparam logic [3:0]   CSC_CH_WIDE_SUB   = 4'h4;

   typedef enum logic [2:0] {
      CSC_MODE_OFF   = 3'b000,
      CSC_MODE_LOW   = 3'b001,
      CSC_MODE_MED   = 3'b010,
      CSC_MODE_HIGH  = 3'b011,
      CSC_MODE_NOISE = 3'b100
   } csc_mode_e;

   typedef enum logic [1:0] {
      CSC_SEL_NONE = 2'b00,
      CSC_SEL_CTRL = 2'b01,
      CSC_SEL_CHAN = 2'b10
   } csc_sel_e;
endpackage

/* File: verilog/csc_sync.sv */
// two-stage level synchroniser
`timescale 1ns/1ps
module csc_sync (
   input  wire logic clk_sys_in,
   input  wire logic rst_b_in,
   input  wire logic async_in,
   output logic      sync_out
);
   typedef struct packed {
      logic s1;
      logic s2;
   } csc_sync_s;

   csc_sync_s st;
   csc_sync_s next_st;

   always_comb begin
      next_st    = st;
      next_st.s1 = async_in;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sync_out = st.s2;
endmodule // csc_sync

/* File: verilog/csc_chan_dec.sv */
// sense channel code to pin one-hot decoder
`timescale 1ns/1ps
module csc_chan_dec
   import csc_pkg::*;
(
   input  wire logic                enable_in,
   input  wire logic                wide_variant_in,
   input  wire logic [3:0]          code_in,
   output logic [CSC_PINS-1:0]      pin_sel_out
);
   logic [3:0] pin_idx;

   always_comb begin
      pin_sel_out = '0;
      pin_idx     = code_in;
      if (code_in > CSC_CH_LAST_BASE) begin
         pin_idx = code_in - CSC_CH_WIDE_SUB;
      end
      if (!enable_in) begin
         pin_sel_out = '0;
      end else if (code_in <= CSC_CH_LAST_BASE) begin
         pin_sel_out[pin_idx[2:0]] = 1'b1;
      end else if (wide_variant_in &&
                   code_in <= CSC_CH_LAST_WIDE) begin
         pin_sel_out[pin_idx[2:0]] = 1'b1;
      end
   end
endmodule // csc_chan_dec

/* File: verilog/csc_top.sv */
// capacitive sense control registers, apb slave and clock routing
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
// Notes on behaviour
// - enable bit turns whole sensing function on
// - range bit picks high or low references
// - low range current field: off, low, med, high
// - high range 00 is noise detection
// - status bit one while sourcing current
// - external timer0 source: oscillator or pin
// - internal timer0 source uses fosc over four
// - unused register bits always read zero
// - codes 0 to 7 pick channels 0-7
// - codes 8 to 11 only on wide variant
// - disabled module connects no channel at all
// - all register bits clear on any reset
// - oscillator runs in sleep while enabled
// - timer may count in sleep, evaluate awake
// - timer0 does not count during sleep
// - timer1 source 11 selects sensing oscillator
module csc_top
   import csc_pkg::*;
(
   input  wire logic                clk_sys_in,
   input  wire logic                rst_b_in,
   input  wire logic                psel_in,
   input  wire logic                penable_in,
   input  wire logic                pwrite_in,
   input  wire logic [CSC_AW-1:0]   paddr_in,
   input  wire logic [CSC_DW-1:0]   pwdata_in,
   input  wire logic [3:0]          pstrb_in,
   output logic                     pready_out,
   output logic [CSC_DW-1:0]        prdata_out,
   output logic                     pslverr_out,
   input  wire logic                osc_direction_in,
   input  wire logic                osc_clk_in,
   input  wire logic                wide_variant_in,
   input  wire logic                sleep_in,
   input  wire logic                timer0_clock_source_select_in,
   input  wire logic                timer0_clock_pin_in,
   input  wire logic                fosc_div4_in,
   input  wire logic [1:0]          timer1_clock_select_in,
   input  wire logic                timer1_other_clk_in,
   output logic                     sense_enable_out,
   output logic                     reference_range_select_out,
   output logic [1:0]               current_range_select_out,
   output logic [2:0]               osc_mode_out,
   output logic                     osc_run_out,
   output logic [CSC_PINS-1:0]      sense_pin_out,
   output logic                     timer0_clk_out,
   output logic                     timer0_count_en_out,
   output logic                     timer1_clk_out
);
   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic                   enable;
      logic                   ref_range;
      logic [1:0]             cur_range;
      logic                   t0_ext_sel;
      logic [3:0]             chan;
      logic [CSC_DW-1:0]      rdata;
      csc_mode_e              mode;
      logic                   run;
      logic [CSC_PINS-1:0]    pins;
      logic                   t0clk;
      logic                   t0en;
      logic                   t1clk;
   } csc_state_s;

   csc_state_s             st;
   csc_state_s             next_st;
   logic                   dir_sync;
   logic [CSC_PINS-1:0]    pin_dec;
   logic                   setup_ph;
   logic                   access_ph;
   csc_sel_e               acc_sel;
   csc_sel_e               set_sel;

   function automatic csc_sel_e csc_decode(input logic [CSC_AW-1:0] a);
      csc_decode = CSC_SEL_NONE;
      if (a == CSC_CTRL_A_ADDR) begin
         csc_decode = CSC_SEL_CTRL;
      end else if (a == CSC_CHANNEL_ADDR) begin
         csc_decode = CSC_SEL_CHAN;
      end
   endfunction

   function automatic logic capsense_chan_low(input logic [3:0] c);
      capsense_chan_low = (c <= CSC_CH_LAST_BASE);
   endfunction

   // ************************************************************
   // helpers
   // ************************************************************
   csc_sync u_dir_sync (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .async_in   (osc_direction_in),
      .sync_out   (dir_sync)
   );

   csc_chan_dec u_chan_dec (
      .enable_in       (st.enable),
      .wide_variant_in (wide_variant_in),
      .code_in         (st.chan),
      .pin_sel_out     (pin_dec)
   );

   assign setup_ph  = psel_in && !penable_in;
   assign access_ph = psel_in && penable_in;
   assign acc_sel   = csc_decode(paddr_in);
   assign set_sel   = acc_sel;

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      next_st = st;
      // register writes take effect at the completing access edge
      if (access_ph && pwrite_in && pstrb_in[0]) begin
         case (acc_sel)
            CSC_SEL_CTRL: begin
               next_st.enable     = pwdata_in[CSC_ENABLE_BIT];
               next_st.ref_range  = pwdata_in[CSC_REFRNG_BIT];
               next_st.cur_range  =
                  pwdata_in[CSC_CURRNG_HI:CSC_CURRNG_LO];
               next_st.t0_ext_sel = pwdata_in[CSC_T0XS_BIT];
            end
            CSC_SEL_CHAN: begin
               next_st.chan = pwdata_in[CSC_CHAN_HI:CSC_CHAN_LO];
            end
            default: begin
               next_st.chan = st.chan;
            end
         endcase
      end
      // read data captured in the setup cycle
      next_st.rdata = CSC_ZERO_WORD;
      if (setup_ph && !pwrite_in) begin
         case (set_sel)
            CSC_SEL_CTRL: begin
               next_st.rdata[CSC_ENABLE_BIT] = st.enable;
               next_st.rdata[CSC_REFRNG_BIT] = st.ref_range;
               next_st.rdata[CSC_CURRNG_HI:CSC_CURRNG_LO] =
                  st.cur_range;
               next_st.rdata[CSC_DIR_BIT]    = dir_sync;
               next_st.rdata[CSC_T0XS_BIT]   = st.t0_ext_sel;
            end
            CSC_SEL_CHAN: begin
               next_st.rdata[CSC_CHAN_HI:CSC_CHAN_LO] = st.chan;
            end
            default: begin
               next_st.rdata = CSC_ZERO_WORD;
            end
         endcase
      end
      // oscillator mode, independent of sleep
      next_st.mode = CSC_MODE_OFF;
      if (st.enable) begin
         case (st.cur_range)
            CSC_CUR_NONE: begin
               next_st.mode = st.ref_range ? CSC_MODE_NOISE
                                           : CSC_MODE_OFF;
            end
            CSC_CUR_LOW:  next_st.mode = CSC_MODE_LOW;
            CSC_CUR_MED:  next_st.mode = CSC_MODE_MED;
            CSC_CUR_HIGH: next_st.mode = CSC_MODE_HIGH;
            default:      next_st.mode = CSC_MODE_OFF;
         endcase
      end
      next_st.run  = (next_st.mode != CSC_MODE_OFF);
      next_st.pins = pin_dec;
      // timer0 clock routing
      if (timer0_clock_source_select_in) begin
         next_st.t0clk = st.t0_ext_sel ? (osc_clk_in && st.run)
                                       : timer0_clock_pin_in;
      end else begin
         next_st.t0clk = fosc_div4_in;
      end
      next_st.t0en = !sleep_in;
      // timer1 keeps counting in sleep
      if (timer1_clock_select_in == CSC_T1_SRC_SENSE) begin
         next_st.t1clk = osc_clk_in && st.run;
      end else begin
         next_st.t1clk = timer1_other_clk_in;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st       <= '0;
         st.mode  <= CSC_MODE_OFF;
      end else begin
         st <= next_st;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign pready_out                 = 1'b1;
   assign pslverr_out = access_ph && (acc_sel == CSC_SEL_NONE);
   assign prdata_out                 = st.rdata;
   assign sense_enable_out           = st.enable;
   assign reference_range_select_out = st.ref_range;
   assign current_range_select_out   = st.cur_range;
   assign osc_mode_out               = st.mode;
   assign osc_run_out                = st.run;
   assign sense_pin_out              = st.pins;
   assign timer0_clk_out             = st.t0clk && st.t0en;
   assign timer0_count_en_out        = st.t0en;
   assign timer1_clk_out             = st.t1clk;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);

   chk_enable_mode: assert property (
      !sense_enable_out |=> osc_mode_out == CSC_MODE_OFF)
      else $error("mode not off while disabled");

   chk_noise_mode: assert property (
      sense_enable_out && reference_range_select_out &&
      current_range_select_out == CSC_CUR_NONE
      |=> osc_mode_out == CSC_MODE_NOISE && osc_run_out)
      else $error("noise mode not entered");

   chk_low_off: assert property (
      reference_range_select_out == 1'b0 &&
      current_range_select_out == CSC_CUR_NONE
      |=> !osc_run_out)
      else $error("low range 00 not off");

   chk_read_zero: assert property (
      ##1 $past(setup_ph) && !$past(pwrite_in)
      |-> prdata_out[CSC_DW-1:CSC_ENABLE_BIT+1] == '0 &&
          prdata_out[5:4] == 2'b00)
      else $error("unused bits read nonzero");

   chk_dir_read: assert property (
      setup_ph && !pwrite_in && set_sel == CSC_SEL_CTRL
      |=> prdata_out[CSC_DIR_BIT] == $past(dir_sync))
      else $error("direction status mismatch");

   chk_chan_none: assert property (
      !sense_enable_out |=> sense_pin_out == '0)
      else $error("channel connected while disabled");

   chk_chan_base: assert property (
      sense_enable_out && capsense_chan_low(st.chan)
      |=> $onehot(sense_pin_out))
      else $error("base channel not connected");

   chk_chan_narrow: assert property (
      !wide_variant_in && st.chan > CSC_CH_LAST_BASE
      |=> sense_pin_out == '0)
      else $error("wide channel on narrow variant");

   chk_t0_sleep: assert property (
      sleep_in |=> !timer0_clk_out)
      else $error("timer0 clocked in sleep");

   chk_t0_internal: assert property (
      !timer0_clock_source_select_in && !sleep_in
      |=> timer0_clk_out == $past(fosc_div4_in))
      else $error("timer0 internal source wrong");

   chk_t1_route: assert property (
      timer1_clock_select_in == CSC_T1_SRC_SENSE
      |=> timer1_clk_out == ($past(osc_clk_in) && $past(osc_run_out)))
      else $error("timer1 not on sense oscillator");

   chk_write_ctrl: assert property (
      access_ph && pwrite_in && pstrb_in[0] &&
      acc_sel == CSC_SEL_CTRL
      |=> sense_enable_out == $past(pwdata_in[CSC_ENABLE_BIT]))
      else $error("enable write lost");

   chk_range_write: assert property (
      access_ph && pwrite_in && pstrb_in[0] &&
      acc_sel == CSC_SEL_CTRL
      |=> reference_range_select_out ==
          $past(pwdata_in[CSC_REFRNG_BIT]))
      else $error("range write lost");

   chk_cur_write: assert property (
      access_ph && pwrite_in && pstrb_in[0] &&
      acc_sel == CSC_SEL_CTRL
      |=> current_range_select_out ==
          $past(pwdata_in[CSC_CURRNG_HI:CSC_CURRNG_LO]))
      else $error("current range write lost");

   chk_chan_write: assert property (
      access_ph && pwrite_in && pstrb_in[0] &&
      acc_sel == CSC_SEL_CHAN
      |=> st.chan == $past(pwdata_in[CSC_CHAN_HI:CSC_CHAN_LO]))
      else $error("channel write lost");

   chk_chan_wide: assert property (
      wide_variant_in && sense_enable_out &&
      st.chan > CSC_CH_LAST_BASE && st.chan <= CSC_CH_LAST_WIDE
      |=> $onehot(sense_pin_out) &&
          sense_pin_out[CSC_PINS-1:CSC_PINS/2] != '0)
      else $error("wide channel not on upper pins");

   chk_sleep_run: assert property (
      sleep_in && sense_enable_out &&
      current_range_select_out != CSC_CUR_NONE
      |=> osc_run_out)
      else $error("oscillator stopped in sleep");

   chk_t0_ext_osc: assert property (
      timer0_clock_source_select_in && st.t0_ext_sel && !sleep_in
      |=> timer0_clk_out == ($past(osc_clk_in) && $past(osc_run_out)))
      else $error("timer0 not on sense oscillator");

   chk_t0_ext_pin: assert property (
      timer0_clock_source_select_in && !st.t0_ext_sel && !sleep_in
      |=> timer0_clk_out == $past(timer0_clock_pin_in))
      else $error("timer0 not on clock pin");

   chk_t0_awake: assert property (
      !sleep_in |=> timer0_count_en_out)
      else $error("timer0 count enable low while awake");

   chk_t1_other: assert property (
      timer1_clock_select_in != CSC_T1_SRC_SENSE
      |=> timer1_clk_out == $past(timer1_other_clk_in))
      else $error("timer1 other source lost");

   chk_rdata_idle: assert property (
      !(setup_ph && !pwrite_in) |=> prdata_out == CSC_ZERO_WORD)
      else $error("read data not cleared");

   cov_noise:  cover property (osc_mode_out == CSC_MODE_NOISE);
   cov_sleep:  cover property (sleep_in && osc_run_out && timer1_clk_out);
   cov_wide:   cover property (wide_variant_in &&
                               st.chan > CSC_CH_LAST_BASE &&
                               sense_pin_out != '0);
   cov_t0osc:  cover property (timer0_clock_source_select_in &&
                               st.t0_ext_sel && timer0_clk_out);
   cov_slverr: cover property (pslverr_out);
endmodule // csc_top

/* File: dv/csc_sense_model.sv */
// far side model: sense oscillator, direction status and timer clocks
`timescale 1ns/1ps
module csc_sense_model (
   input  wire logic clk_sys_in,
   input  wire logic rst_b_in,
   input  wire logic osc_run_in,
   input  wire logic dir_level_in,
   output logic      osc_direction_out,
   output logic      osc_clk_out,
   output logic      timer0_clock_pin_out,
   output logic      fosc_div4_out,
   output logic      timer1_other_clk_out
);
   // ************************************************************
   // clock sources
   // ************************************************************
   logic [4:0] phase;

   // phase keeps running while the part sleeps
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         phase <= 5'h00;
      end else begin
         phase <= phase + 5'h01;
      end
   end

   // oscillator stands still while not running
   assign osc_clk_out          = osc_run_in & phase[1];
   assign osc_direction_out    = dir_level_in;
   assign timer0_clock_pin_out = phase[2];
   assign fosc_div4_out        = phase[3];
   assign timer1_other_clk_out = phase[4];
endmodule // csc_sense_model

/* File: dv/csc_top_tb_top.sv */
// self-checking bench of the capacitive sense control block
`timescale 1ns/1ps
module csc_top_tb_top;
   import csc_pkg::*;
   typedef struct {logic [7:0] ctrl; logic [2:0] mode; logic [7:0] rd;}
      csc_row_s;
   logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'h0;
   logic pready, pslverr, err, dir = 1'b0, wide = 1'b0, sleep = 1'b0;
   logic tcs = 1'b0, odir, oclk, t0pin, fdiv, t1oth, en, rng, run, t0c;
   logic t0en, t1c;
   logic [1:0] t1sel = 2'h0, cur;
   logic [2:0] mode;
   logic [7:0] pins;
   int fail_count = 0, num_checks = 0, i, w, n;
   csc_row_s rows [9] = '{'{8'h80, 3'h0, 8'h80}, '{8'h84, 3'h1, 8'h84},
      '{8'h88, 3'h2, 8'h88}, '{8'h8c, 3'h3, 8'h8c}, '{8'hc0, 3'h4, 8'hc0},
      '{8'hc4, 3'h1, 8'hc4}, '{8'hc8, 3'h2, 8'hc8}, '{8'hcf, 3'h3, 8'hcd},
      '{8'h3f, 3'h0, 8'h0d}};

   always #10 clk = ~clk;

   csc_top dut (.clk_sys_in(clk), .rst_b_in(rst_b), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
      .pwdata_in(pwdata), .pstrb_in(pstrb), .pready_out(pready),
      .prdata_out(prdata), .pslverr_out(pslverr), .osc_direction_in(odir),
      .osc_clk_in(oclk), .wide_variant_in(wide), .sleep_in(sleep),
      .timer0_clock_source_select_in(tcs), .timer0_clock_pin_in(t0pin),
      .fosc_div4_in(fdiv), .timer1_clock_select_in(t1sel),
      .timer1_other_clk_in(t1oth), .sense_enable_out(en),
      .reference_range_select_out(rng), .current_range_select_out(cur),
      .osc_mode_out(mode), .osc_run_out(run), .sense_pin_out(pins),
      .timer0_clk_out(t0c), .timer0_count_en_out(t0en),
      .timer1_clk_out(t1c));

   csc_sense_model far (.clk_sys_in(clk), .rst_b_in(rst_b),
      .osc_run_in(run), .dir_level_in(dir), .osc_direction_out(odir),
      .osc_clk_out(oclk), .timer0_clock_pin_out(t0pin),
      .fosc_div4_out(fdiv), .timer1_other_clk_out(t1oth));

   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1; pwr <= wr; paddr <= a; pwdata <= d; pstrb <= 4'hf;
      @(posedge clk);
      pen <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (k == 20) begin
         fail_count++;
         tally_and_finish();
      end else begin
         rd = prdata;
         err = pslverr;
         psel <= 1'b0; pen <= 1'b0;
      end
   endtask

   task automatic settle();
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask

   // clear at start of the base, capture the count at its end
   task automatic count(input logic pick, output int c);
      logic prev, now;
      c = 0;
      prev = 1'b1;
      repeat (64) begin
         @(negedge clk);
         now = pick ? t1c : t0c;
         if (now === 1'b1 && prev === 1'b0) c++;
         prev = now;
      end
   endtask

   function automatic logic near(input int c, e);
      return (c >= e - 1) && (c <= e + 1);
   endfunction

   function automatic logic [7:0] pins_of(input logic [3:0] c, input int v);
      if (c <= 4'h7) return 8'h01 << c;
      if (v == 1 && c <= 4'hb) return 8'h01 << (c - 4'h4);
      return 8'h00;
   endfunction

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      apb(1'b0, CSC_CTRL_A_ADDR, 32'h0);
      check("ctrl reset", rd, 32'h0);
      apb(1'b0, CSC_CHANNEL_ADDR, 32'h0);
      check("chan reset", rd, 32'h0);
      $display("reset test done");
      foreach (rows[r]) begin
         apb(1'b1, CSC_CTRL_A_ADDR, {24'hffffff, rows[r].ctrl});
         settle();
         check("mode", mode, rows[r].mode);
         check("run", run, rows[r].mode != 3'h0);
         check("en", en, rows[r].ctrl[7]);
         check("range", rng, rows[r].ctrl[6]);
         check("cur", cur, rows[r].ctrl[3:2]);
         apb(1'b0, CSC_CTRL_A_ADDR, 32'h0);
         check("ctrl read", rd, {24'h0, rows[r].rd});
      end
      $display("mode table done");
      apb(1'b1, CSC_CTRL_A_ADDR, 32'h84);
      for (w = 0; w < 2; w++) begin
         wide <= w[0];
         for (i = 0; i < 12; i++) begin
            apb(1'b1, CSC_CHANNEL_ADDR, 32'hf0 | i);
            settle();
            check("pins", pins, pins_of(i[3:0], w));
            apb(1'b0, CSC_CHANNEL_ADDR, 32'h0);
            check("chan read", rd, i);
         end
      end
      apb(1'b1, CSC_CTRL_A_ADDR, 32'h04);
      settle();
      check("pins off", pins, 8'h00);
      $display("channel test done");
      apb(1'b1, 12'h008, 32'hff);
      check("unmapped err", err, 1'b1);
      apb(1'b0, 12'h008, 32'h0);
      check("unmapped data", rd, 32'h0);
      check("unmapped err", err, 1'b1);
      dir <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b0, CSC_CTRL_A_ADDR, 32'h0);
      check("dir status", rd, 32'h06);
      dir <= 1'b0;
      $display("status test done");
      tcs <= 1'b1;
      apb(1'b1, CSC_CTRL_A_ADDR, 32'h85);
      count(1'b0, n);
      check("t0 osc", near(n, 16), 1'b1);
      i = n;
      apb(1'b1, CSC_CTRL_A_ADDR, 32'h84);
      count(1'b0, n);
      check("t0 pin", near(n, 8), 1'b1);
      check("slow below midway", n < (i + n) / 2, 1'b1);
      tcs <= 1'b0;
      apb(1'b1, CSC_CTRL_A_ADDR, 32'h85);
      count(1'b0, n);
      check("t0 fosc", near(n, 4), 1'b1);
      tcs <= 1'b1;
      sleep <= 1'b1;
      t1sel <= CSC_T1_SRC_SENSE;
      count(1'b0, n);
      check("t0 sleep", n, 32'h0);
      check("t0 count en", t0en, 1'b0);
      check("run in sleep", run, 1'b1);
      count(1'b1, n);
      check("t1 osc", near(n, 16), 1'b1);
      t1sel <= 2'h0;
      count(1'b1, n);
      check("t1 other", near(n, 2), 1'b1);
      sleep <= 1'b0;
      $display("timer test done");
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      apb(1'b0, CSC_CTRL_A_ADDR, 32'h0);
      check("ctrl rereset", rd, 32'h0);
      apb(1'b0, CSC_CHANNEL_ADDR, 32'h0);
      check("chan rereset", rd, 32'h0);
      check("pins rereset", pins, 8'h00);
      $display("second reset done");
      tally_and_finish();
   end
endmodule // csc_top_tb_top
